// >>> cesh_ctl.sv
// Controller end: APB slave that queues device register commands
// through a 4-word FIFO and guards software ordering.
// Assumes the device answers reads one cycle after taking them.
`timescale 1ns/100ps
`default_nettype none
module cesh_ctl (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cesh_link_if.ctl bus
);
  import cesh_pkg::*;

  logic [7:0] ctrl_shadow_ff;
  logic refused_ff;
  logic rd_valid_ff;
  logic [7:0] rd_data_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [CMD_W-1:0] fifo_out;

  // APB decode
  wire access = psel & penable;
  wire hit_cmd = (paddr == APB_CMD);
  wire hit_stat = (paddr == APB_STAT);
  wire cmd_wr = access & pwrite & hit_cmd;
  wire stat_wr = access & pwrite & hit_stat & pready;

  // Command fields
  wire c_write = pwdata[CMD_WR_POS];
  wire [9:0] c_addr = pwdata[CMD_ADDR_LSB +: ADDR_W];
  wire [7:0] c_data = pwdata[7:0];
  wire c_chan = (c_addr == REG_CHAN_EN);
  wire c_sync = (c_addr == REG_SYNC_SEL);
  wire c_ctrl = (c_addr == REG_LINK_CTRL);
  wire tx_on = ctrl_shadow_ff[CTRL_TX_POS];
  wire cal_on = ctrl_shadow_ff[CTRL_CAL_POS];

  // channel change needs link and calibration off
  wire bad_busy = c_chan & (tx_on | cal_on);
  wire bad_none = c_chan & (c_data[1:0] == 2'b00);
  // one-channel mode needs first pair on
  wire bad_one = c_chan & c_data[ONE_CH_POS] & ~c_data[FIRST_POS];
  // sync mode changes only with link off
  wire bad_sync = c_sync & tx_on;
  wire refuse = c_write & (bad_busy | bad_none | bad_one | bad_sync);

  wire [7:0] clean = c_chan ? (c_data & CHAN_EN_MASK) :
                     c_sync ? (c_data & SYNC_SEL_MASK) :
                     c_ctrl ? (c_data & LINK_CTRL_MASK) : c_data;

  // Full FIFO stalls the bus, so back-pressure reaches software
  wire push = cmd_wr & ~refuse;
  assign pready = ~(push & ~fifo_in_ready);
  assign pslverr = access & ~hit_cmd & ~hit_stat;
  wire taken = push & fifo_in_ready;

  cesh_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(CMD_DEPTH)
  ) u_cmd_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({c_write, c_addr, clean}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(bus.req_ready),
    .out_data_o(fifo_out)
  );

  // FIFO head drives the device port
  assign bus.req_valid = fifo_out_valid;
  assign bus.req_write = fifo_out[CMD_W-1];
  assign bus.req_addr = fifo_out[DATA_W +: ADDR_W];
  assign bus.req_wdata = fifo_out[DATA_W-1:0];

  // Status read mux
  wire [31:0] stat_word = {16'h0000, rd_data_ff, 5'h00, rd_valid_ff,
                           refused_ff, ~fifo_out_valid};
  assign prdata = hit_stat ? stat_word : 32'h0000_0000;

  // Shadow of link control, updated in queue order
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_shadow_ff <= LINK_CTRL_RST;
    end else if (taken & c_write & c_ctrl) begin
      ctrl_shadow_ff <= clean;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  wire nxt_refused = (cmd_wr & refuse) |
                     (refused_ff & ~(stat_wr & pwdata[STAT_REFUSE_POS]));
  wire nxt_rd_valid = bus.rsp_valid |
                      (rd_valid_ff & ~(stat_wr & pwdata[STAT_RDV_POS]));
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      refused_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      refused_ff <= nxt_refused;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= bus.rsp_valid ? bus.rsp_rdata : rd_data_ff;
    end
  end
endmodule
`default_nettype wire

// >>> cesh_dev.sv
// Device end: channel-pair enables, lane/converter scaling, frame slot
// placement and 64B/66B sync word content.
// Assumes the controller keeps the software-side ordering rules.
// Behaviour
// - One-channel flag turns off B, C, D
// - One-channel mode needs first pair on
// - Second-pair bit switches channels C, D
// - First-pair bit switches channels A, B
// - Stop calibration and link before changes
// - Never clear both pair enables
// - Pair off halves lanes and converters
// - Odd base lanes get tail padding when halved
// - First pair off moves C, D forward
// - Reserved bits written as zero
// - Sync mode picks CRC, FEC or reserved
// - Sync mode only in 64B/66B format
// - Command fields always sent as zero
// - Sync mode changes only, link off
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module cesh_dev (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  cesh_link_if.dev bus,
  input wire logic [cesh_pkg::LANE_W-1:0] base_lane_count_i,
  input wire logic [cesh_pkg::LANE_W-1:0] base_converter_count_i,
  input wire logic [cesh_pkg::SAMP_W-1:0] samp_a_i,
  input wire logic [cesh_pkg::SAMP_W-1:0] samp_b_i,
  input wire logic [cesh_pkg::SAMP_W-1:0] samp_c_i,
  input wire logic [cesh_pkg::SAMP_W-1:0] samp_d_i,
  input wire logic mb_strobe_i,
  input wire logic [cesh_pkg::CRC_W-1:0] crc_i,
  input wire logic [cesh_pkg::FEC_W-1:0] fec_i,
  output logic [3:0] chan_on_o,
  output logic [cesh_pkg::LANE_W-1:0] lane_count_o,
  output logic [cesh_pkg::LANE_W-1:0] conv_count_o,
  output logic tail_pad_o,
  output logic [cesh_pkg::SAMP_W-1:0] slot0_o,
  output logic [cesh_pkg::SAMP_W-1:0] slot1_o,
  output logic [cesh_pkg::SAMP_W-1:0] slot2_o,
  output logic [cesh_pkg::SAMP_W-1:0] slot3_o,
  output logic link_tx_on_o,
  output logic cal_on_o,
  output logic sync_valid_o,
  output logic [cesh_pkg::SYNC_W-1:0] sync_word_o
);
  import cesh_pkg::*;

  logic [7:0] chan_en_ff;
  logic [7:0] sync_sel_ff;
  logic [7:0] link_ctrl_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_rdata_ff;
  logic [3:0] chan_on_ff;
  logic [LANE_W-1:0] lane_ff;
  logic [LANE_W-1:0] conv_ff;
  logic tail_ff;
  logic [SAMP_W-1:0] slot_ff [4];
  logic sync_valid_ff;
  logic [SYNC_W-1:0] sync_word_ff;

  // Register port never stalls; every request is taken at once
  assign bus.req_ready = 1'b1;
  wire take = bus.req_valid;
  wire wr_take = take & bus.req_write;
  wire rd_take = take & ~bus.req_write;
  wire hit_chan = (bus.req_addr == REG_CHAN_EN);
  wire hit_sync = (bus.req_addr == REG_SYNC_SEL);
  wire hit_ctrl = (bus.req_addr == REG_LINK_CTRL);
  wire hit_stat = (bus.req_addr == REG_LINK_STAT);

  // Decoded control fields
  wire first_pair_on = chan_en_ff[FIRST_POS];
  wire second_pair_on = chan_en_ff[SECOND_POS];
  wire one_channel_select = chan_en_ff[ONE_CH_POS];
  wire link_tx_on = link_ctrl_ff[CTRL_TX_POS];
  wire fmt_64b66b = link_ctrl_ff[CTRL_FMT_POS];
  wire [1:0] sync_header_select = sync_sel_ff[1:0];

  wire one_ch = one_channel_select;
  // first pair gates A and B
  wire nxt_a_on = first_pair_on;
  wire nxt_b_on = first_pair_on & ~one_ch;
  // second pair gates C and D
  wire nxt_cd_on = second_pair_on & ~one_ch;
  wire [3:0] nxt_chan_on = {nxt_cd_on, nxt_cd_on, nxt_b_on, nxt_a_on};

  // any pair off halves the link
  wire pair_off = ~first_pair_on | ~second_pair_on | one_ch;
  wire [LANE_W:0] lane_sum = {1'b0, base_lane_count_i} + 5'h01;
  wire [LANE_W-1:0] lane_half = lane_sum[LANE_W:1];
  wire [LANE_W-1:0] conv_half = {1'b0, base_converter_count_i[LANE_W-1:1]};
  wire [LANE_W-1:0] nxt_lane = pair_off ? lane_half : base_lane_count_i;
  wire [LANE_W-1:0] nxt_conv = pair_off ? conv_half : base_converter_count_i;
  // odd base lane count pads last lane when the link is halved
  wire nxt_tail = pair_off & base_lane_count_i[0];

  // Frame slot placement
  logic [SAMP_W-1:0] nxt_slot [4];
  always_comb begin
    nxt_slot[0] = samp_a_i;
    nxt_slot[1] = nxt_b_on ? samp_b_i : '0;
    nxt_slot[2] = samp_c_i;
    nxt_slot[3] = samp_d_i;
    if (!first_pair_on) begin
      // C and D take the A and B slots
      nxt_slot[0] = nxt_cd_on ? samp_c_i : '0;
      nxt_slot[1] = nxt_cd_on ? samp_d_i : '0;
      nxt_slot[2] = '0;
      nxt_slot[3] = '0;
    end else if (pair_off) begin
      // A stays, B stays unless one-channel mode, C and D dropped
      nxt_slot[2] = '0;
      nxt_slot[3] = '0;
    end
  end

  // Sync word; command bits above the payload are idle zero
  logic [SYNC_W-1:0] nxt_sync;
  always_comb begin
    nxt_sync = '0;
    unique case (cesh_sh_e'(sync_header_select))
      CESH_SH_CRC: nxt_sync = {20'h00000, crc_i};
      CESH_SH_FEC: nxt_sync = {6'h00, fec_i};
      CESH_SH_RSV1: nxt_sync = '0;
      CESH_SH_RSV3: nxt_sync = '0;
    endcase
  end
  wire sync_live = fmt_64b66b & link_tx_on;

  // Read mux; unmapped addresses read zero
  wire [7:0] stat_word = {tail_ff, 3'h0, chan_on_ff};
  wire [7:0] rd_mux = hit_chan ? chan_en_ff :
                      hit_sync ? sync_sel_ff :
                      hit_ctrl ? link_ctrl_ff :
                      hit_stat ? stat_word : 8'h00;

  // Registers keep only defined bits, so reserved bits read zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan_en_ff <= CHAN_EN_RST;
      sync_sel_ff <= SYNC_SEL_RST;
      link_ctrl_ff <= LINK_CTRL_RST;
    end else if (wr_take) begin
      if (hit_chan) begin
        chan_en_ff <= bus.req_wdata & CHAN_EN_MASK;
      end
      if (hit_sync) begin
        sync_sel_ff <= bus.req_wdata & SYNC_SEL_MASK;
      end
      if (hit_ctrl) begin
        link_ctrl_ff <= bus.req_wdata & LINK_CTRL_MASK;
      end
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
    end else begin
      rsp_valid_ff <= rd_take;
      rsp_rdata_ff <= rd_take ? rd_mux : rsp_rdata_ff;
    end
  end

  // Registered framing outputs, one cycle behind config and samples
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan_on_ff <= 4'h0;
      lane_ff <= '0;
      conv_ff <= '0;
      tail_ff <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        slot_ff[i] <= '0;
      end
    end else begin
      chan_on_ff <= nxt_chan_on;
      lane_ff <= nxt_lane;
      conv_ff <= nxt_conv;
      tail_ff <= nxt_tail;
      for (int i = 0; i < 4; i++) begin
        slot_ff[i] <= nxt_slot[i];
      end
    end
  end

  // Sync word latched per multiblock strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync_valid_ff <= 1'b0;
      sync_word_ff <= '0;
    end else begin
      sync_valid_ff <= mb_strobe_i & sync_live;
      if (mb_strobe_i & sync_live) begin
        sync_word_ff <= nxt_sync;
      end
    end
  end

  assign bus.rsp_valid = rsp_valid_ff;
  assign bus.rsp_rdata = rsp_rdata_ff;
  assign chan_on_o = chan_on_ff;
  assign lane_count_o = lane_ff;
  assign conv_count_o = conv_ff;
  assign tail_pad_o = tail_ff;
  assign slot0_o = slot_ff[0];
  assign slot1_o = slot_ff[1];
  assign slot2_o = slot_ff[2];
  assign slot3_o = slot_ff[3];
  assign link_tx_on_o = link_ctrl_ff[CTRL_TX_POS];
  assign cal_on_o = link_ctrl_ff[CTRL_CAL_POS];
  assign sync_valid_o = sync_valid_ff;
  assign sync_word_o = sync_word_ff;
endmodule
`default_nettype wire

// >>> cesh_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cesh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // Honest flags straight from the occupancy count
  assign in_ready_o = (count_ff != (PW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o = mem_ff[rd_ptr_ff];

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers wrap; depth is a power of two
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> cesh_link_assertions.sv
// Checker on the register link between controller and device end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module cesh_link_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [9:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata
);
  import cesh_pkg::*;
  logic [1:0] ctrl_ff;
  logic [7:0] chan_ff;
  // Transfers taken on the wire
  wire wr_take = req_valid && req_ready && req_write;
  wire rd_take = req_valid && req_ready && !req_write;
  wire chan_wr = wr_take && req_addr == REG_CHAN_EN;
  wire sync_wr = wr_take && req_addr == REG_SYNC_SEL;
  wire chan_rd = rd_take && req_addr == REG_CHAN_EN;
  // Shadows of link/cal enables and pair enables, as the device holds them
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= 2'h0;
      chan_ff <= CHAN_EN_RST;
    end else begin
      if (wr_take && req_addr == REG_LINK_CTRL) begin
        ctrl_ff <= req_wdata[1:0];
      end
      if (chan_wr) begin
        chan_ff <= req_wdata;
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_chan_link_off: assert property (chan_wr |-> ctrl_ff == 2'h0)
    else $error("pair enables changed while link or cal on");
  a_chan_rsv_zero: assert property (chan_wr |-> req_wdata[7:3] == 5'h00)
    else $error("reserved pair enable bits sent nonzero");
  a_sync_rsv_zero: assert property (sync_wr |-> req_wdata[7:2] == 6'h00)
    else $error("reserved sync select bits sent nonzero");
  a_one_ch_first: assert property (chan_wr && req_wdata[2] |-> req_wdata[0])
    else $error("one channel mode sent without first pair");
  a_pairs_not_off: assert property (chan_wr |-> req_wdata[1:0] != 2'h0)
    else $error("both pairs switched off");
  a_sync_link_off: assert property (sync_wr |-> !ctrl_ff[0])
    else $error("sync select changed while link on");
  a_read_answer: assert property (rd_take |=> rsp_valid)
    else $error("read not answered next cycle");
  a_rsp_cause: assert property (rsp_valid |-> $past(rd_take))
    else $error("answer without a read");
  // One request per cycle, so no write can slip between read and answer
  a_chan_readback: assert property (rsp_valid && $past(chan_rd) |->
    rsp_rdata == chan_ff)
    else $error("pair enable readback differs from last write");
  c_chan_wr: cover property (chan_wr);
  c_sync_wr: cover property (sync_wr);
  c_read: cover property (rd_take ##1 rsp_valid);
endmodule
`default_nettype wire

// >>> cesh_link_if.sv
// Register port between the controller and the device end.
// Assumes one clock shared by both ends; the bench instantiates it.
`timescale 1ns/100ps
`default_nettype none
interface cesh_link_if;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic [9:0] req_addr;
  logic [7:0] req_wdata;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  modport dev (
    input req_valid, req_write, req_addr, req_wdata,
    output req_ready, rsp_valid, rsp_rdata
  );
  modport ctl (
    output req_valid, req_write, req_addr, req_wdata,
    input req_ready, rsp_valid, rsp_rdata
  );
endinterface
`default_nettype wire

// >>> cesh_pkg.sv
// Shared constants for the channel-enable / sync-header configuration block.
// Assumes both ends and the bench import this package.
package cesh_pkg;
  // Device register port
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam logic [9:0] REG_CHAN_EN = 10'h209;
  localparam logic [9:0] REG_SYNC_SEL = 10'h20F;
  localparam logic [9:0] REG_LINK_CTRL = 10'h200;
  localparam logic [9:0] REG_LINK_STAT = 10'h201;
  localparam logic [7:0] CHAN_EN_RST = 8'h03;
  localparam logic [7:0] SYNC_SEL_RST = 8'h00;
  localparam logic [7:0] LINK_CTRL_RST = 8'h00;
  localparam logic [7:0] CHAN_EN_MASK = 8'h07;
  localparam logic [7:0] SYNC_SEL_MASK = 8'h03;
  localparam logic [7:0] LINK_CTRL_MASK = 8'h07;
  // Field positions
  localparam int unsigned FIRST_POS = 0;
  localparam int unsigned SECOND_POS = 1;
  localparam int unsigned ONE_CH_POS = 2;
  localparam int unsigned CTRL_TX_POS = 0;
  localparam int unsigned CTRL_CAL_POS = 1;
  localparam int unsigned CTRL_FMT_POS = 2;
  // Sync word content selection
  typedef enum logic [1:0] {
    CESH_SH_CRC = 2'b00,
    CESH_SH_RSV1 = 2'b01,
    CESH_SH_FEC = 2'b10,
    CESH_SH_RSV3 = 2'b11
  } cesh_sh_e;
  // Frame and sync word widths
  localparam int unsigned SAMP_W = 9;
  localparam int unsigned LANE_W = 4;
  localparam int unsigned CRC_W = 12;
  localparam int unsigned FEC_W = 26;
  localparam int unsigned SYNC_W = 32;
  // Controller APB map
  localparam logic [31:0] APB_CMD = 32'h0000_0000;
  localparam logic [31:0] APB_STAT = 32'h0000_0004;
  localparam int unsigned CMD_WR_POS = 31;
  localparam int unsigned CMD_ADDR_LSB = 16;
  localparam int unsigned STAT_EMPTY_POS = 0;
  localparam int unsigned STAT_REFUSE_POS = 1;
  localparam int unsigned STAT_RDV_POS = 2;
  localparam int unsigned STAT_RD_LSB = 8;
  localparam int unsigned CMD_W = 1 + ADDR_W + DATA_W;
  localparam int unsigned CMD_DEPTH = 4;
endpackage

// >>> tb.sv
// Bench: APB drives the controller, the link joins it to the device end.
// Assumes one 200 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cesh_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] on;
    logic [3:0] lane;
    logic [3:0] conv;
    logic tail;
    logic [35:0] slots;
  } cesh_row_s;
  logic sys_clk = 1'b0, rst_n = 1'b0, strobe = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, sw_w;
  logic pready, pslverr, perr, tail_w, tx_w, cal_w, sv_w;
  logic [3:0] lanes = 4'h5, convs = 4'h4, on_w, lane_w, conv_w;
  logic [8:0] sa = 9'h011, sb = 9'h022, sc = 9'h033, sd = 9'h044;
  logic [8:0] s0, s1, s2, s3;
  logic [11:0] crc = 12'hA5C;
  logic [25:0] fec = 26'h2B4C3D1;
  int err_count = 0, comparisons = 0, cyc = 0;
  cesh_row_s rows [5];
  cesh_link_if cesh_link_if_inst ();
  // 5 ns clock
  always #2.5 sys_clk = ~sys_clk;
  cesh_ctl cesh_ctl_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(cesh_link_if_inst));
  cesh_dev cesh_dev_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .bus(cesh_link_if_inst), .base_lane_count_i(lanes),
    .base_converter_count_i(convs), .samp_a_i(sa), .samp_b_i(sb),
    .samp_c_i(sc), .samp_d_i(sd), .mb_strobe_i(strobe), .crc_i(crc),
    .fec_i(fec), .chan_on_o(on_w), .lane_count_o(lane_w),
    .conv_count_o(conv_w), .tail_pad_o(tail_w), .slot0_o(s0),
    .slot1_o(s1), .slot2_o(s2), .slot3_o(s3), .link_tx_on_o(tx_w),
    .cal_on_o(cal_w), .sync_valid_o(sv_w), .sync_word_o(sw_w));
  cesh_link_assertions cesh_link_assertions_inst (.sys_clk_i(sys_clk),
    .rst_n_i(rst_n), .req_valid(cesh_link_if_inst.req_valid),
    .req_ready(cesh_link_if_inst.req_ready),
    .req_write(cesh_link_if_inst.req_write),
    .req_addr(cesh_link_if_inst.req_addr),
    .req_wdata(cesh_link_if_inst.req_wdata),
    .rsp_valid(cesh_link_if_inst.rsp_valid),
    .rsp_rdata(cesh_link_if_inst.rsp_rdata));
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Called just after a rising edge; request held until pready seen high
  // at a rising edge, answer taken there, then one idle edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic dwr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, APB_CMD, {1'b1, 5'h00, a, 8'h00, d});
  endtask
  // Device read: queue it, poll status, clear the sticky flag
  task automatic drd(input logic [9:0] a);
    logic [7:0] v;
    apb(1'b1, APB_CMD, {1'b0, 5'h00, a, 16'h0000});
    rd = 32'h0;
    while (rd[STAT_RDV_POS] !== 1'b1) apb(1'b0, APB_STAT, 32'h0);
    v = rd[15:8];
    apb(1'b1, APB_STAT, 32'h4);
    rd = {24'h0, v};
  endtask
  task automatic pulse(input logic [31:0] exp_w, input logic exp_v);
    @(posedge sys_clk);
    strobe <= 1'b1;
    @(posedge sys_clk);
    strobe <= 1'b0;
    @(negedge sys_clk);
    chk(sv_w, exp_v);
    if (exp_v) chk(sw_w, exp_w);
    // Back on a rising edge before the next bus call
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] sync_exp(input logic [1:0] m);
    case (m)
      CESH_SH_CRC: return {20'h0, crc};
      CESH_SH_FEC: return {6'h0, fec};
      default: return 32'h0;
    endcase
  endfunction
  initial begin
    rows[0] = '{8'h03, 4'hF, 4'h5, 4'h4, 1'b0, {sa, sb, sc, sd}};
    rows[1] = '{8'h01, 4'h3, 4'h3, 4'h2, 1'b1, {sa, sb, 18'h0}};
    rows[2] = '{8'h02, 4'hC, 4'h3, 4'h2, 1'b1, {sc, sd, 18'h0}};
    rows[3] = '{8'h05, 4'h1, 4'h3, 4'h2, 1'b1, {sa, 27'h0}};
    rows[4] = '{8'h07, 4'h1, 4'h3, 4'h2, 1'b1, {sa, 27'h0}};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Pair settings against counts and slots
    foreach (rows[i]) begin
      dwr(REG_CHAN_EN, rows[i].cfg);
      drd(REG_CHAN_EN);
      chk(rd, rows[i].cfg);
      chk(on_w, rows[i].on);
      chk({lane_w, conv_w, tail_w},
          {rows[i].lane, rows[i].conv, rows[i].tail});
      chk({s0, s1, s2, s3}, rows[i].slots);
    end
    // Even base lanes: halved, no padding
    @(posedge sys_clk);
    lanes <= 4'h4;
    dwr(REG_CHAN_EN, 8'h01);
    drd(REG_CHAN_EN);
    chk({lane_w, conv_w, tail_w}, {4'h2, 4'h2, 1'b0});
    lanes <= 4'h5;
    // Reserved bits masked, illegal settings dropped
    dwr(REG_CHAN_EN, 8'hFB);
    dwr(REG_CHAN_EN, 8'h00);
    dwr(REG_CHAN_EN, 8'h06);
    apb(1'b0, APB_STAT, 32'h0);
    chk(rd[STAT_REFUSE_POS], 1'b1);
    apb(1'b1, APB_STAT, 32'h2);
    drd(REG_CHAN_EN);
    chk(rd, 32'h03);
    dwr(REG_LINK_CTRL, 8'h02);
    dwr(REG_CHAN_EN, 8'h01);
    drd(REG_CHAN_EN);
    chk({cal_w, rd}, {1'b1, 32'h03});
    // Every sync select code with the link live in 64B/66B
    for (int m = 0; m < 4; m++) begin
      dwr(REG_LINK_CTRL, 8'h04);
      dwr(REG_SYNC_SEL, 8'(m));
      dwr(REG_LINK_CTRL, 8'h05);
      drd(REG_SYNC_SEL);
      chk({tx_w, rd}, {1'b1, 32'(m)});
      pulse(sync_exp(2'(m)), 1'b1);
    end
    dwr(REG_SYNC_SEL, 8'h00);
    drd(REG_SYNC_SEL);
    chk(rd, 32'h03);
    dwr(REG_LINK_CTRL, 8'h01);
    drd(REG_LINK_CTRL);
    chk(rd, 32'h01);
    pulse(32'h0, 1'b0);
    apb(1'b0, 32'h8, 32'h0);
    chk({perr, rd}, {1'b1, 32'h0});
    // Leave a non-default pair setting so the reset check can trip
    dwr(REG_LINK_CTRL, 8'h00);
    dwr(REG_CHAN_EN, 8'h02);
    drd(REG_CHAN_EN);
    chk(rd, 32'h02);
    // Reset in mid-run restores register defaults
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    drd(REG_CHAN_EN);
    chk(rd, 32'h03);
    drd(REG_SYNC_SEL);
    chk(rd, 32'h00);
    chk({on_w, lane_w, conv_w}, {4'hF, 4'h5, 4'h4});
    give_verdict();
  end
endmodule
`default_nettype wire
